// [rtl/iep_pkg.sv]
// Package of constants for the interrupt enable and priority register bank.
// Assumes an 8-bit special-function-register bus with direct byte addresses.
package iep_pkg;
  // ==========================================================================
  // Register addresses.
  localparam logic [7:0] ADDR_EXT_FLAGS  = 8'h91;
  localparam logic [7:0] ADDR_ENABLE     = 8'hA8;
  localparam logic [7:0] ADDR_PRIORITY   = 8'hB8;
  localparam logic [7:0] ADDR_EXT_CTRL   = 8'hD8;
  localparam logic [7:0] ADDR_CAUSE      = 8'hE4;
  localparam logic [7:0] ADDR_EXT_ENABLE = 8'hE8;
  localparam logic [7:0] ADDR_EXT_PRIO   = 8'hF8;
  // ==========================================================================
  // Reset values and reserved read masks.
  localparam logic [7:0] RESET_VALUE     = 8'h00;
  localparam logic [7:0] ONES_PRIORITY   = 8'h80;
  localparam logic [7:0] ONES_EXT_FLAGS  = 8'h08;
  localparam logic [7:0] ONES_EXT_CTRL   = 8'h40;
  localparam logic [7:0] ONES_EXT_EN_PRI = 8'hE0;
  // ==========================================================================
  // Field positions.
  localparam int BIT_GLOBAL     = 7;
  localparam int BIT_RATE_DBL   = 7;
  localparam int BIT_EXT0_FLAG  = 5;
  localparam int BIT_CONV_FLAG  = 4;
  localparam int BIT_EXT_TWO_FLAG_FLAG  = 3;
  localparam int BIT_EXT_TWO_FLAG_EN    = 4;
  localparam int BIT_EXT0_EN    = 1;
  localparam int BIT_CONV_EN    = 0;
  // ==========================================================================
  // Peripheral cause codes.
  localparam logic [7:0] CODE_OVERRUN  = 8'h01;
  localparam logic [7:0] CODE_TX_EMPTY = 8'h03;
  localparam logic [7:0] CODE_RX_AVAIL = 8'h05;
  localparam logic [7:0] CODE_NONE     = 8'h00;
  // Number of sources in natural order.
  localparam int NUM_SRC = 10;
  // Instruction cycle length in clocks.
  localparam int INSTR_CLKS = 4;
endpackage

// [rtl/iep_regs.sv]
// Interrupt enable, priority and edge flag registers with request arbitration.
// Assumes a core issuing one-cycle write and read strobes with an SFR address,
// and returning i_instr_done once per instruction and i_reti on return.
module iep_regs (
  input  wire logic                 i_clk_sys,        // System clock.
  input  wire logic                 i_reset_n,        // Async reset, low.
  input  wire logic [7:0]           i_sfr_addr,       // Register address.
  input  wire logic [7:0]           i_sfr_wdata,      // Write data.
  input  wire logic                 i_sfr_wr,         // Write strobe.
  input  wire logic                 i_sfr_rd,         // Read strobe.
  input  wire logic                 i_periph_n,       // Peripheral line, low.
  input  wire logic                 i_timer_zero_overflow, // Timer 0 flag.
  input  wire logic                 i_ext_one_pin_n,  // External 1 request.
  input  wire logic                 i_timer_one_overflow,  // Timer 1 flag.
  input  wire logic                 i_serial_zero_tx_flag, // Serial 0 tx.
  input  wire logic                 i_serial_zero_rx_flag, // Serial 0 rx.
  input  wire logic                 i_timer_two_overflow,  // Timer 2 flag.
  input  wire logic                 i_serial_one_tx_flag,  // Serial 1 tx.
  input  wire logic                 i_serial_one_rx_flag,  // Serial 1 rx.
  input  wire logic                 i_converter_irq,  // Converter input.
  input  wire logic                 i_ext_zero_pin_n, // External 0 pin.
  input  wire logic                 i_ext_two_pin,    // External 2 pin.
  input  wire logic                 i_spi_overrun,    // Cause: rx overrun.
  input  wire logic                 i_spi_tx_empty,   // Cause: tx empty.
  input  wire logic                 i_spi_rx_avail,   // Cause: rx data.
  input  wire logic                 i_instr_done,     // Instruction end pulse.
  input  wire logic                 i_reti,           // Return executed pulse.
  input  wire logic                 i_vector_taken,   // Core took request.
  output logic [7:0]                o_sfr_rdata,      // Read data.
  output logic                      o_irq_req,        // Request to core.
  output logic [3:0]                o_irq_id,         // Winning source.
  output logic                      o_irq_high,       // Winner is high level.
  output logic                      o_serial_one_rate_double // Rate doubler.
);
  import iep_pkg::*;

  // ==========================================================================
  // Storage.
  logic [7:0] irq_enable;
  logic [6:0] irq_priority;
  logic       ext_zero_edge_flag;
  logic       converter_edge_flag;
  logic       ext_two_flag;
  logic       ext_two_irq_on;
  logic       ext_zero_irq_on;
  logic       converter_irq_on;
  logic       ext_two_level;
  logic       ext_zero_prio_level;
  logic       converter_level;
  logic [7:0] periph_cause_code;
  logic       ext_zero_prev_n;
  logic       conv_prev;
  logic       ext_two_prev;
  logic       active_low;
  logic       active_high;
  logic       hold_one;
  logic       hold_pending;

  logic wr_en;
  logic wr_ext_flags;
  logic wr_ext_ctrl;
  logic ext_zero_fall;
  logic conv_rise;
  logic ext_two_rise;
  logic ctl_write;
  assign wr_en        = i_sfr_wr && (i_sfr_addr == ADDR_ENABLE);
  assign wr_ext_flags = i_sfr_wr && (i_sfr_addr == ADDR_EXT_FLAGS);
  assign wr_ext_ctrl  = i_sfr_wr && (i_sfr_addr == ADDR_EXT_CTRL);
  assign ext_zero_fall = ext_zero_prev_n && !i_ext_zero_pin_n;
  assign conv_rise     = !conv_prev && i_converter_irq;
  assign ext_two_rise  = !ext_two_prev && i_ext_two_pin;
  // Writes to any enable or priority register start the post-write hold.
  assign ctl_write = i_sfr_wr && ((i_sfr_addr == ADDR_ENABLE) ||
                     (i_sfr_addr == ADDR_PRIORITY) || (i_sfr_addr == ADDR_EXT_ENABLE) ||
                     (i_sfr_addr == ADDR_EXT_PRIO));

  // Standard enable and priority registers.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_enable   <= RESET_VALUE;
      irq_priority <= RESET_VALUE[6:0];
    end else if (i_sfr_wr) begin
      if (wr_en) begin
        irq_enable <= i_sfr_wdata;
      end
      if (i_sfr_addr == ADDR_PRIORITY) begin
        irq_priority <= i_sfr_wdata[6:0];
      end
    end
  end

  // Extended enable, priority and rate doubler registers.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_two_irq_on         <= 1'b0;
      ext_zero_irq_on        <= 1'b0;
      converter_irq_on       <= 1'b0;
      ext_two_level          <= 1'b0;
      ext_zero_prio_level    <= 1'b0;
      converter_level        <= 1'b0;
      o_serial_one_rate_double <= 1'b0;
    end else if (i_sfr_wr) begin
      if (i_sfr_addr == ADDR_EXT_ENABLE) begin
        ext_two_irq_on   <= i_sfr_wdata[BIT_EXT_TWO_FLAG_EN];
        ext_zero_irq_on  <= i_sfr_wdata[BIT_EXT0_EN];
        converter_irq_on <= i_sfr_wdata[BIT_CONV_EN];
      end
      if (i_sfr_addr == ADDR_EXT_PRIO) begin
        ext_two_level       <= i_sfr_wdata[BIT_EXT_TWO_FLAG_EN];
        ext_zero_prio_level <= i_sfr_wdata[BIT_EXT0_EN];
        converter_level     <= i_sfr_wdata[BIT_CONV_EN];
      end
      if (wr_ext_ctrl) begin
        o_serial_one_rate_double <= i_sfr_wdata[BIT_RATE_DBL];
      end
    end
  end

  // Edge detectors; the pins are taken as already synchronous.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_zero_prev_n <= 1'b1;
      conv_prev       <= 1'b0;
      ext_two_prev    <= 1'b0;
    end else begin
      ext_zero_prev_n <= i_ext_zero_pin_n;
      conv_prev       <= i_converter_irq;
      ext_two_prev    <= i_ext_two_pin;
    end
  end

  // Edge flags: software may write either value, but an edge in the same
  // cycle wins so that no event is lost.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_zero_edge_flag  <= 1'b0;
      converter_edge_flag <= 1'b0;
      ext_two_flag        <= 1'b0;
    end else begin
      if (ext_zero_fall) begin
        ext_zero_edge_flag <= 1'b1;
      end else if (wr_ext_flags) begin
        ext_zero_edge_flag <= i_sfr_wdata[BIT_EXT0_FLAG];
      end
      if (conv_rise) begin
        converter_edge_flag <= 1'b1;
      end else if (wr_ext_flags) begin
        converter_edge_flag <= i_sfr_wdata[BIT_CONV_FLAG];
      end
      if (ext_two_rise) begin
        ext_two_flag <= 1'b1;
      end else if (wr_ext_ctrl) begin
        ext_two_flag <= i_sfr_wdata[BIT_EXT_TWO_FLAG_FLAG];
      end
    end
  end

  // Peripheral cause encoder, registered; overrun ranks first.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      periph_cause_code <= CODE_NONE;
    end else if (i_spi_overrun) begin
      periph_cause_code <= CODE_OVERRUN;
    end else if (i_spi_tx_empty) begin
      periph_cause_code <= CODE_TX_EMPTY;
    end else if (i_spi_rx_avail) begin
      periph_cause_code <= CODE_RX_AVAIL;
    end else begin
      periph_cause_code <= CODE_NONE;
    end
  end

  // Read data, with reserved bits forced to their fixed values.
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    unique case (i_sfr_addr)
      ADDR_ENABLE:     next_rdata = irq_enable;
      ADDR_PRIORITY:   next_rdata = ONES_PRIORITY | {1'b0, irq_priority};
      ADDR_EXT_FLAGS:  next_rdata = ONES_EXT_FLAGS |
                                    {2'b00, ext_zero_edge_flag, converter_edge_flag,
                                     4'h0};
      ADDR_EXT_CTRL:   next_rdata = ONES_EXT_CTRL |
                                    {o_serial_one_rate_double, 3'b000, ext_two_flag,
                                     3'b000};
      ADDR_CAUSE:      next_rdata = periph_cause_code;
      ADDR_EXT_ENABLE: next_rdata = ONES_EXT_EN_PRI |
                                    {3'b000, ext_two_irq_on, 2'b00, ext_zero_irq_on,
                                     converter_irq_on};
      ADDR_EXT_PRIO:   next_rdata = ONES_EXT_EN_PRI |
                                    {3'b000, ext_two_level, 2'b00, ext_zero_prio_level,
                                     converter_level};
      default:         next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= next_rdata;
    end
  end

  // Per-source requests and levels in natural order, index 0 highest.
  logic [NUM_SRC-1:0] raw_req;
  logic [NUM_SRC-1:0] src_on;
  logic [NUM_SRC-1:0] src_lvl;
  logic [NUM_SRC-1:0] gated;
  assign raw_req = {ext_two_flag, ext_zero_edge_flag, converter_edge_flag,
                    i_serial_one_tx_flag | i_serial_one_rx_flag,
                    i_timer_two_overflow,
                    i_serial_zero_tx_flag | i_serial_zero_rx_flag,
                    i_timer_one_overflow,
                    !i_ext_one_pin_n,
                    i_timer_zero_overflow,
                    !i_periph_n};
  assign src_on  = {ext_two_irq_on, ext_zero_irq_on, converter_irq_on, irq_enable[6:0]};
  assign src_lvl = {ext_two_level, ext_zero_prio_level, converter_level,
                    irq_priority[6:0]};

  // Global gate masks everything while clear.
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_gate
      assign gated[g] = irq_enable[BIT_GLOBAL] & src_on[g] & raw_req[g];
    end
  endgenerate

  // Pick the lowest index at the high level first, then at the low level.
  logic       next_req;
  logic [3:0] next_id;
  logic       next_high;
  always_comb begin
    next_req  = 1'b0;
    next_id   = 4'h0;
    next_high = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (gated[i] && !src_lvl[i] && !active_low && !active_high) begin
        next_req = 1'b1;
        next_id  = 4'(i);
      end
    end
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (gated[i] && src_lvl[i] && !active_high) begin
        next_req  = 1'b1;
        next_id   = 4'(i);
        next_high = 1'b1;
      end
    end
    // A return or control write in this very cycle already starts the hold,
    // otherwise a request could slip out one cycle after it.
    if (hold_one || hold_pending || i_reti || ctl_write) begin
      next_req = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq_req  <= 1'b0;
      o_irq_id   <= 4'h0;
      o_irq_high <= 1'b0;
    end else begin
      o_irq_req  <= next_req;
      o_irq_id   <= next_id;
      o_irq_high <= next_high;
    end
  end

  // In-service levels: a return ends the higher active level first.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      active_low  <= 1'b0;
      active_high <= 1'b0;
    end else if (i_vector_taken && o_irq_req) begin
      if (o_irq_high) begin
        active_high <= 1'b1;
      end else begin
        active_low <= 1'b1;
      end
    end else if (i_reti) begin
      if (active_high) begin
        active_high <= 1'b0;
      end else begin
        active_low <= 1'b0;
      end
    end
  end

  // After a return or a control write, let one more instruction finish.
  // The pending stage waits for the current instruction, then hold_one
  // covers the next one.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_pending <= 1'b0;
      hold_one     <= 1'b0;
    end else if (i_reti || ctl_write) begin
      hold_pending <= 1'b1;
      hold_one     <= 1'b0;
    end else if (i_instr_done) begin
      hold_one     <= hold_pending;
      hold_pending <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks.
  a_global_mask: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !irq_enable[BIT_GLOBAL] |=> !o_irq_req)
    else $error("Request raised while global gate clear.");
  a_ext0_edge: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $fell(i_ext_zero_pin_n) |=> ext_zero_edge_flag)
    else $error("External zero edge not flagged.");
  a_conv_edge: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(i_converter_irq) |=> converter_edge_flag)
    else $error("Converter edge not flagged.");
  a_ext_two_flag_edge: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (ext_two_rise && wr_ext_ctrl) |=> ext_two_flag)
    else $error("External two edge lost to clear.");
  a_rate_dbl: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    wr_ext_ctrl |=> o_serial_one_rate_double == $past(i_sfr_wdata[7]))
    else $error("Rate doubler not updated.");
  a_cause_code: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_spi_overrun |=> periph_cause_code == CODE_OVERRUN)
    else $error("Overrun not ranked first.");
  a_cause_read: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_sfr_rd && i_sfr_addr == ADDR_CAUSE) |=> o_sfr_rdata == $past(periph_cause_code))
    else $error("Cause register read wrong.");
  a_prio_ones: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_sfr_rd && i_sfr_addr == ADDR_PRIORITY) |=> o_sfr_rdata[7])
    else $error("Reserved priority bit not one.");
  a_flag_zeros: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_sfr_rd && i_sfr_addr == ADDR_EXT_FLAGS) |=> o_sfr_rdata[2:0] == 3'b000)
    else $error("Reserved flag bits not zero.");
  a_high_preempt: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    active_high |=> !o_irq_req)
    else $error("Request during high level service.");
  a_hold_after: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_reti |=> !o_irq_req ##1 !o_irq_req)
    else $error("Request too soon after return.");
  a_serial_one: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !irq_enable[6] |=> !(o_irq_req && o_irq_id == 4'h6))
    else $error("Serial one passed while disabled.");
  a_prio_order: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (next_req && !next_high && gated[1] && !src_lvl[1]) |-> next_id <= 4'h1)
    else $error("Natural order violated.");

  c_high_req: cover property (@(posedge i_clk_sys) o_irq_req && o_irq_high);
  c_low_req: cover property (@(posedge i_clk_sys) o_irq_req && !o_irq_high);
  c_ext0_set: cover property (@(posedge i_clk_sys) $rose(ext_zero_edge_flag));
  c_nested: cover property (@(posedge i_clk_sys) active_low && active_high);
endmodule

// [tb/iep_core_model.sv]
// Behavioural core that sits on the far side of the interrupt register bank.
// Assumes the bench commands vector acceptance and returns by level inputs.
module iep_core_model (
  input  wire logic i_clk_sys,      // System clock.
  input  wire logic i_reset_n,      // Async reset, low.
  input  wire logic i_irq_req,      // Request from the bank.
  input  wire logic i_accept,       // Bench lets the core take vectors.
  input  wire logic i_return,       // Bench asks for a return.
  output logic      o_instr_done,   // Instruction end pulse.
  output logic      o_vector_taken, // Vector accepted pulse.
  output logic      o_reti          // Return pulse.
);
  timeunit 1ns;
  timeprecision 100ps;
  import iep_pkg::*;
  logic [1:0] phase;
  logic       ret_q;
  // ==========================================================================
  // Fixed-length instructions give the hold after returns and writes its pace.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase        <= 2'h0;
      o_instr_done <= 1'b0;
    end else begin
      phase        <= phase + 2'h1;
      o_instr_done <= (phase == 2'(INSTR_CLKS - 1));
    end
  end
  // ==========================================================================
  // One acceptance per request; the gap cycle stops a stale request retaking.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_vector_taken <= 1'b0;
      ret_q          <= 1'b0;
      o_reti         <= 1'b0;
    end else begin
      o_vector_taken <= i_accept && i_irq_req && !o_vector_taken;
      ret_q          <= i_return;
      o_reti         <= i_return && !ret_q;
    end
  end
endmodule

// [tb/iep_regs_test.sv]
// Self-checking bench for the interrupt enable and priority register bank.
// Assumes the core model above and one-cycle register strobes.
module iep_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import iep_pkg::*;
  logic       clk, reset_n, wr, rd, accept, ret;
  logic [7:0] addr, wdata, rdata;
  logic [9:0] src;
  logic [1:0] alt;
  logic [2:0] cause;
  logic       done, taken, reti, req, high, dbl;
  logic [3:0] id;
  int         errors, tests_run;
  logic [7:0] a_tab [8] = '{8'h91, 8'hA8, 8'hB8, 8'hD8, 8'hE4, 8'hE8, 8'hF8, 8'h90};
  logic [7:0] r_tab [8] = '{8'h08, 8'h00, 8'h80, 8'h40, 8'h00, 8'hE0, 8'hE0, 8'h00};
  logic [7:0] f_tab [8] = '{8'h38, 8'hFF, 8'hFF, 8'hC8, 8'h00, 8'hF3, 8'hF3, 8'h00};
  logic [2:0] e_bit [3] = '{3'h0, 3'h1, 3'h4};
  // ==========================================================================
  // Design and core model.
  iep_regs uut (
    .i_clk_sys(clk), .i_reset_n(reset_n), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .i_periph_n(~src[0]), .i_timer_zero_overflow(src[1]),
    .i_ext_one_pin_n(~src[2]), .i_timer_one_overflow(src[3]),
    .i_serial_zero_tx_flag(src[4]), .i_serial_zero_rx_flag(alt[0]),
    .i_timer_two_overflow(src[5]), .i_serial_one_tx_flag(alt[1]),
    .i_serial_one_rx_flag(src[6]), .i_converter_irq(src[7]), .i_ext_zero_pin_n(~src[8]),
    .i_ext_two_pin(src[9]), .i_spi_overrun(cause[2]), .i_spi_tx_empty(cause[1]),
    .i_spi_rx_avail(cause[0]), .i_instr_done(done), .i_reti(reti),
    .i_vector_taken(taken), .o_sfr_rdata(rdata), .o_irq_req(req), .o_irq_id(id),
    .o_irq_high(high), .o_serial_one_rate_double(dbl));
  iep_core_model core (
    .i_clk_sys(clk), .i_reset_n(reset_n), .i_irq_req(req), .i_accept(accept),
    .i_return(ret), .o_instr_done(done), .o_vector_taken(taken), .o_reti(reti));
  // ==========================================================================
  // Bus and comparison tasks.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    #1 check(rdata, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // The hold after a write spans up to two instructions, so allow ample time.
  task automatic wait_req(input logic [3:0] exp_id);
    int k;
    // Step off the edge so that a request launched on it is not raced.
    #1;
    for (k = 0; k < 60 && req !== 1'b1; k++) idle(1);
    if (k == 60) begin
      check({7'h00, req}, 8'h01);
      conclude();
    end else begin
      check({4'h0, id}, {4'h0, exp_id});
    end
  endtask
  task automatic conclude();
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock at 4 ns and the main sequence.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    src = 10'h000;
    alt = 2'b00;
    cause = 3'h0;
    accept = 1'b0;
    ret = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values, reserved bits and the unmapped address.
    foreach (a_tab[j]) rd_chk(a_tab[j], r_tab[j]);
    foreach (a_tab[j]) wr_reg(a_tab[j], 8'hFF);
    foreach (a_tab[j]) rd_chk(a_tab[j], f_tab[j]);
    check({7'h00, dbl}, 8'h01);
    foreach (a_tab[j]) wr_reg(a_tab[j], 8'h00);
    idle(2);
    check({7'h00, dbl}, 8'h00);
    // Encoder ranking over every cause combination.
    for (int c = 0; c < 8; c++) begin
      cause <= 3'(c);
      idle(3);
      rd_chk(ADDR_CAUSE, c[2] ? 8'h01 : c[1] ? 8'h03 : c[0] ? 8'h05 : 8'h00);
    end
    cause <= 3'h0;
    // Each source: masked by the global gate, then passed by its own bit.
    for (int i = 0; i < 10; i++) begin
      wr_reg(i < 7 ? ADDR_ENABLE : ADDR_EXT_ENABLE,
             i < 7 ? 8'(1 << i) : 8'(1 << e_bit[i-7]));
      src[i] <= 1'b1;
      idle(16);
      check({7'h00, req}, 8'h00);
      wr_reg(ADDR_ENABLE, i < 7 ? 8'(8'h80 | (1 << i)) : 8'h80);
      wait_req(4'(i));
      if (i == 7) rd_chk(ADDR_EXT_FLAGS, 8'h18);
      if (i == 8) rd_chk(ADDR_EXT_FLAGS, 8'h28);
      if (i == 9) rd_chk(ADDR_EXT_CTRL, 8'h48);
      src[i] <= 1'b0;
      wr_reg(ADDR_EXT_FLAGS, 8'h00);
      wr_reg(ADDR_EXT_CTRL, 8'h00);
      wr_reg(ADDR_EXT_ENABLE, 8'h00);
      wr_reg(ADDR_ENABLE, 8'h00);
      idle(2);
      check({7'h00, req}, 8'h00);
    end
    // The other flag of each serial port raises the same request.
    wr_reg(ADDR_ENABLE, 8'hD0);
    alt <= 2'b01;
    wait_req(4'h4);
    alt <= 2'b10;
    idle(2);
    wait_req(4'h6);
    alt <= 2'b00;
    wr_reg(ADDR_ENABLE, 8'h00);
    // An external two edge in the cycle of a clearing write still sets the flag.
    @(posedge clk);
    addr   <= ADDR_EXT_CTRL;
    wdata  <= 8'h00;
    wr     <= 1'b1;
    src[9] <= 1'b1;
    @(posedge clk);
    wr     <= 1'b0;
    rd_chk(ADDR_EXT_CTRL, 8'h48);
    src[9] <= 1'b0;
    wr_reg(ADDR_EXT_CTRL, 8'h00);
    // A software write of the external zero flag raises its request.
    wr_reg(ADDR_EXT_ENABLE, 8'h02);
    wr_reg(ADDR_ENABLE, 8'h80);
    wr_reg(ADDR_EXT_FLAGS, 8'h20);
    wait_req(4'h8);
    wr_reg(ADDR_EXT_FLAGS, 8'h00);
    wr_reg(ADDR_EXT_ENABLE, 8'h00);
    // Level beats natural order; an active high routine is not preempted.
    wr_reg(ADDR_PRIORITY, 8'h08);
    src[1] <= 1'b1;
    src[3] <= 1'b1;
    wr_reg(ADDR_ENABLE, 8'h8A);
    wait_req(4'h3);
    check({7'h00, high}, 8'h01);
    accept <= 1'b1;
    idle(3);
    accept <= 1'b0;
    idle(12);
    check({7'h00, req}, 8'h00);
    ret <= 1'b1;
    idle(2);
    ret <= 1'b0;
    wait_req(4'h3);
    wr_reg(ADDR_PRIORITY, 8'h00);
    idle(2);
    wait_req(4'h1);
    check({7'h00, high}, 8'h00);
    conclude();
  end
endmodule
